// File: test/pipelined_sync_sram_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pipelined_sync_sram_control_tb;
   import sram_ctrl_pkg::*;
   // Command codes: gate_n, select_two, store_n, step
   localparam logic [3:0] RD = 4'h6, WR = 4'h4, ST = 4'h1, DS = 4'h2, HOLD = 4'hA;
   logic SYS_CLK_IN = 1'b0, RST_B_IN = 1'b0, CLK_EN_IN = 1'b1, CLOCK_GATE_N_IN = 1'b1;
   logic SELECT_ONE_N_IN = 1'b0, SELECT_TWO_IN = 1'b0, SELECT_THREE_N_IN = 1'b0, go = 1'b0;
   logic STORE_SELECT_N_IN = 1'b1, BURST_STEP_IN = 1'b0, OUTPUT_DRIVE_N_IN = 1'b0;
   logic BURST_ORDER_SELECT_N_IN = 1'b0, SLEEP_REQUEST_IN = 1'b0, LATENCY_SELECT_N_IN = 1'b1;
   logic LANE_ONE_STROBE_N_IN = 1'b1, LANE_TWO_STROBE_N_IN = 1'b1;
   logic LANE_THREE_STROBE_N_IN = 1'b1, LANE_FOUR_STROBE_N_IN = 1'b1;
   logic [5:0]        ADDR_IN = 6'h00;
   logic [DATA_W-1:0] DQ_IN, DQ_OUT, wdata = DQ_RST;
   logic [DATA_W-1:0] mem [64];
   logic              DQ_OE_OUT, SLEEP_ACTIVE_OUT;
   int                n_errors = 0, n_checks = 0;
   sync_sram_core #(.ADDR_W(6)) dut_u (.*);
   sram_data_src master_u (.clk_in(SYS_CLK_IN), .go_in(go), .flow_in(!LATENCY_SELECT_N_IN),
                           .data_in(wdata), .dq_out(DQ_IN));
   always #5 SYS_CLK_IN = ~SYS_CLK_IN;
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   function automatic logic [5:0] nth(input logic [5:0] b, input logic [1:0] i);
      return {b[5:2], BURST_ORDER_SELECT_N_IN ? b[1:0] ^ i : b[1:0] + i};
   endfunction : nth
   task automatic cmd(input logic [3:0] c, input logic [5:0] a, input logic [3:0] ln, input logic [DATA_W-1:0] d);
      @(posedge SYS_CLK_IN);
      {CLOCK_GATE_N_IN, SELECT_TWO_IN, STORE_SELECT_N_IN, BURST_STEP_IN} <= c;
      {LANE_FOUR_STROBE_N_IN, LANE_THREE_STROBE_N_IN, LANE_TWO_STROBE_N_IN, LANE_ONE_STROBE_N_IN} <= ln;
      ADDR_IN <= a;
      wdata   <= d;
      go      <= ~&ln;
   endtask : cmd
   task automatic wr(input logic [5:0] a, input int n, input logic [3:0] ln, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] v;
      for (int i = 0; i <= n; i++) begin
         v = d + DATA_W'(i);
         cmd(i ? ST : WR, a, ln, v);
         for (int j = 0; j < LANES; j++) begin
            if (!ln[j]) mem[nth(a, 2'(i))][j*LANE_W +: LANE_W] = v[j*LANE_W +: LANE_W];
         end
      end
      repeat (3) cmd(DS, a, 4'hF, v);
   endtask : wr
   task automatic rd(input logic [5:0] a, input int n, input logic oe);
      cmd(RD, a, 4'hF, wdata);
      repeat (n) cmd(ST, a, 4'hF, wdata);
      repeat (LATENCY_SELECT_N_IN ? 3 : 2) cmd(DS, a, 4'hF, wdata);
      @(posedge SYS_CLK_IN);
      #1;
      check(DATA_W'(DQ_OE_OUT), DATA_W'(oe));
      if (oe) check(DQ_OUT, mem[nth(a, 2'(n))]);
   endtask : rd
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge SYS_CLK_IN);
      RST_B_IN <= 1'b1;
      #1;
      check(DATA_W'(DQ_OE_OUT), DQ_RST);
      for (int m = 0; m < 2; m++) begin
         @(posedge SYS_CLK_IN);
         LATENCY_SELECT_N_IN     <= !m;
         BURST_ORDER_SELECT_N_IN <= m;
         repeat (3) cmd(DS, 6'h00, 4'hF, wdata);
         cmd(ST, 6'h00, 4'hF, wdata);
         wr(6'h01, 0, 4'h0, 36'h1_2345_6789 + m);
         rd(6'h01, 0, 1'b1);
         wr(6'h01, 0, 4'hD, 36'hA_BCDE_F012);
         rd(6'h01, 0, 1'b1);
         wr(6'h01, 0, 4'hF, 36'hF_FFFF_FFFF);
         rd(6'h01, 0, 1'b1);
         wr(6'h05, 3, 4'h0, 36'h0_0000_0040 + 16 * m);
         rd(6'h05, 3, 1'b1);
         if (m == 0) begin
            cmd(RD, 6'h01, 4'hF, wdata);
            cmd(DS, 6'h01, 4'hF, wdata);
            repeat (6) cmd(HOLD, 6'h01, 4'hF, wdata);
            #1;
            check(DQ_OUT, mem[1]);
            check(DATA_W'(DQ_OE_OUT), 36'h1);
            @(posedge SYS_CLK_IN);
            CLK_EN_IN <= 1'b0;
            repeat (4) @(posedge SYS_CLK_IN);
            CLK_EN_IN <= 1'b1;
            #1;
            check(DQ_OUT, mem[1]);
            check(DATA_W'(DQ_OE_OUT), 36'h1);
         end
      end
      @(posedge SYS_CLK_IN);
      OUTPUT_DRIVE_N_IN <= 1'b1;
      rd(6'h01, 0, 1'b0);
      @(posedge SYS_CLK_IN);
      SLEEP_REQUEST_IN <= 1'b1;
      repeat (8) @(posedge SYS_CLK_IN);
      #1;
      check(DATA_W'(SLEEP_ACTIVE_OUT), 36'h1);
      check(DATA_W'(DQ_OE_OUT), 36'h0);
      print_verdict();
   end
   initial begin
      #20000;
      n_errors++;
      print_verdict();
   end
endmodule : pipelined_sync_sram_control_tb
`default_nettype wire

// File: test/sram_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sram_chk
   import sram_ctrl_pkg::*;
(
   input wire logic              SYS_CLK_IN,
   input wire logic              RST_B_IN,
   input wire logic              CLK_EN_IN,
   input wire logic              CLOCK_GATE_N_IN,
   input wire logic              SELECT_ONE_N_IN,
   input wire logic              SELECT_TWO_IN,
   input wire logic              SELECT_THREE_N_IN,
   input wire logic              STORE_SELECT_N_IN,
   input wire logic              BURST_STEP_IN,
   input wire logic              OUTPUT_DRIVE_N_IN,
   input wire logic              SLEEP_REQUEST_IN,
   input wire logic              LATENCY_SELECT_N_IN,
   input wire logic [DATA_W-1:0] DQ_OUT,
   input wire logic              DQ_OE_OUT,
   input wire logic              SLEEP_ACTIVE_OUT
);
   // ---------------------------------------------------------------
   // Pin timing seen through the two-flop input stage
   // ---------------------------------------------------------------
   wire logic run  = CLK_EN_IN && !CLOCK_GATE_N_IN && !SLEEP_REQUEST_IN && !SLEEP_ACTIVE_OUT;
   wire logic sel  = !SELECT_ONE_N_IN && SELECT_TWO_IN && !SELECT_THREE_N_IN;
   wire logic load = run && !BURST_STEP_IN;
   wire logic drv  = !OUTPUT_DRIVE_N_IN;
   wire logic pipe = LATENCY_SELECT_N_IN;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   reset_float_a: assert property (disable iff (1'b0)
      !RST_B_IN |=> !DQ_OE_OUT && DQ_OUT == DQ_RST) else $error("Outputs active after reset");
   pipe_read_a: assert property (
      (load && sel && STORE_SELECT_N_IN && pipe && drv) ##1 (run && drv) ##1 drv[*2] |=> DQ_OE_OUT)
      else $error("Pipelined read not driven");
   flow_read_a: assert property (
      (load && sel && STORE_SELECT_N_IN && !pipe && drv) ##1 (run && drv) |-> ##2 DQ_OE_OUT)
      else $error("Flow-through read not driven");
   write_float_a: assert property (
      (load && sel && !STORE_SELECT_N_IN && pipe) ##1 run |-> ##3 !DQ_OE_OUT) else $error("Bus driven on write");
   deselect_float_a: assert property (
      (load && !sel && pipe) ##1 run |-> ##3 !DQ_OE_OUT) else $error("Bus driven when deselected");
   dummy_read_a: assert property (
      OUTPUT_DRIVE_N_IN[*3] |=> !DQ_OE_OUT) else $error("Bus driven with drive disabled");
   sleep_float_a: assert property (
      SLEEP_ACTIVE_OUT |-> !DQ_OE_OUT) else $error("Bus driven while asleep");
   sleep_enter_a: assert property (
      (SLEEP_REQUEST_IN && CLK_EN_IN)[*6] |=> SLEEP_ACTIVE_OUT) else $error("Sleep not entered");
   stall_hold_a: assert property (
      (CLOCK_GATE_N_IN && CLK_EN_IN && drv && !SLEEP_REQUEST_IN)[*4] |=> $stable(DQ_OUT) && $stable(DQ_OE_OUT))
      else $error("Outputs moved during stall");
endmodule : sram_chk
bind sync_sram_core sram_chk chk_u (.*);
`default_nettype wire

// File: test/sram_data_src.sv
`timescale 1ns/10ps
`default_nettype none
module sram_data_src
   import sram_ctrl_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              go_in,
   input  wire logic              flow_in,
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] dq_out
);
   // ---------------------------------------------------------------
   // Late write data, one or two edges behind the command
   // ---------------------------------------------------------------
   logic              hold_r;
   logic [DATA_W-1:0] stage_r;
   always_ff @(posedge clk_in) begin
      hold_r  <= go_in;
      stage_r <= data_in;
   end
   // A released bus shows inverted data, so a late capture cannot match by luck
   always_ff @(posedge clk_in) begin
      if (flow_in ? go_in : hold_r) begin
         dq_out <= flow_in ? data_in : stage_r;
      end else begin
         dq_out <= ~stage_r;
      end
   end
endmodule : sram_data_src
`default_nettype wire

// File: verilog/sram_ctrl_pkg.sv
package sram_ctrl_pkg;

   // ---------------------------------------------------------------
   // Data organisation
   // ---------------------------------------------------------------
   localparam int LANE_W     = 9;
   localparam int LANES      = 4;
   localparam int DATA_W     = LANE_W * LANES;
   localparam int ADDR_W_DEF = 19;
   localparam int BURST_W    = 2;

   // ---------------------------------------------------------------
   // Control pin bundle field positions
   // ---------------------------------------------------------------
   localparam int CTL_GATE   = 0;
   localparam int CTL_SEL1   = 1;
   localparam int CTL_SEL2   = 2;
   localparam int CTL_SEL3   = 3;
   localparam int CTL_STORE  = 4;
   localparam int CTL_STEP   = 5;
   localparam int CTL_LANE0  = 6;
   localparam int CTL_DRIVE  = 10;
   localparam int CTL_ORDER  = 11;
   localparam int CTL_SLEEP  = 12;
   localparam int CTL_LAT    = 13;
   localparam int CTL_W      = 14;

   // ---------------------------------------------------------------
   // Reset values and timing
   // ---------------------------------------------------------------
   // Idle pins: stalled, deselected, no strobes, drive off, linear, pipelined
   localparam logic [CTL_W-1:0]   CTL_RST      = 14'h27DB;
   localparam logic [BURST_W-1:0] CNT_RST      = 2'h0;
   localparam logic [BURST_W-1:0] CNT_ONE      = 2'h1;
   localparam logic [LANES-1:0]   LANES_NONE   = 4'h0;
   localparam logic [DATA_W-1:0]  DQ_RST       = 36'h0_0000_0000;
   localparam int                 SLEEP_CYCLES = 2;

   typedef enum logic [1:0] {
      OP_DESEL,
      OP_READ,
      OP_WRITE
   } op_t;

endpackage : sram_ctrl_pkg

// File: verilog/sync_sram_core.sv
// Summary of operation
// - Clock gate high freezes all state except the input flops and sleep delay
// - Inputs sampled on rising edge only
// - Selected only with all three selects active
// - Read starts on selected load, store high
// - Pipelined read data drives one edge later
// - Write registers enables, lanes, address together
// - Each lane strobe gates its own lane
// - All strobes high aborts write, bus floats
// - Flow-through read data drives right after command
// - Burst step continues previous operation type
// - Two-bit counter steps every continue cycle
// - Read with drive disable is dummy read
// - Drivers off during writes regardless of enable
// - Stall holds bus driven or floating
// - Outputs float from power-up until commanded
// - Drive enable and sleep act without clock; here both pass the two input flops, clocked under clock enable
// - Latency select low means flow-through
// - Step uses counter address, load reloads it
// - Counter wraps after four, linear or interleaved
// - Sleep two cycles after request, outputs float
`timescale 1ns/10ps
`default_nettype none

module sync_sram_core
   import sram_ctrl_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input  wire logic              SYS_CLK_IN,
   input  wire logic              RST_B_IN,
   input  wire logic              CLK_EN_IN,
   input  wire logic              CLOCK_GATE_N_IN,
   input  wire logic              SELECT_ONE_N_IN,
   input  wire logic              SELECT_TWO_IN,
   input  wire logic              SELECT_THREE_N_IN,
   input  wire logic              STORE_SELECT_N_IN,
   input  wire logic              BURST_STEP_IN,
   input  wire logic              LANE_ONE_STROBE_N_IN,
   input  wire logic              LANE_TWO_STROBE_N_IN,
   input  wire logic              LANE_THREE_STROBE_N_IN,
   input  wire logic              LANE_FOUR_STROBE_N_IN,
   input  wire logic              OUTPUT_DRIVE_N_IN,
   input  wire logic              BURST_ORDER_SELECT_N_IN,
   input  wire logic              SLEEP_REQUEST_IN,
   input  wire logic              LATENCY_SELECT_N_IN,
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic [DATA_W-1:0] DQ_IN,
   output logic      [DATA_W-1:0] DQ_OUT,
   output logic                   DQ_OE_OUT,
   output logic                   SLEEP_ACTIVE_OUT
);
   import sram_ctrl_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Every pin but clock enable and reset, the clockless ones too, passes two flops; this adds
   // two cycles of fixed delay in front of the documented timing.
   logic [CTL_W-1:0]  ctl_s1_r;
   logic [CTL_W-1:0]  ctl_s2_r;
   logic [ADDR_W-1:0] addr_s1_r;
   logic [ADDR_W-1:0] addr_s2_r;
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;
   logic [CTL_W-1:0]  ctl_pins;

   assign ctl_pins = {LATENCY_SELECT_N_IN,
                      SLEEP_REQUEST_IN,
                      BURST_ORDER_SELECT_N_IN,
                      OUTPUT_DRIVE_N_IN,
                      LANE_FOUR_STROBE_N_IN,
                      LANE_THREE_STROBE_N_IN,
                      LANE_TWO_STROBE_N_IN,
                      LANE_ONE_STROBE_N_IN,
                      BURST_STEP_IN,
                      STORE_SELECT_N_IN,
                      SELECT_THREE_N_IN,
                      SELECT_TWO_IN,
                      SELECT_ONE_N_IN,
                      CLOCK_GATE_N_IN};

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         ctl_s1_r  <= CTL_RST;
         ctl_s2_r  <= CTL_RST;
         addr_s1_r <= '0;
         addr_s2_r <= '0;
         dq_s1_r   <= DQ_RST;
         dq_s2_r   <= DQ_RST;
      end else if (CLK_EN_IN) begin
         ctl_s1_r  <= ctl_pins;
         ctl_s2_r  <= ctl_s1_r;
         addr_s1_r <= ADDR_IN;
         addr_s2_r <= addr_s1_r;
         dq_s1_r   <= DQ_IN;
         dq_s2_r   <= dq_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // Sleep entry
   // ---------------------------------------------------------------
   logic [SLEEP_CYCLES-1:0] sleep_dly_r;
   logic                    asleep;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         sleep_dly_r <= '0;
      end else if (CLK_EN_IN) begin
         sleep_dly_r <= {sleep_dly_r[SLEEP_CYCLES-2:0], ctl_s2_r[CTL_SLEEP]};
      end
   end

   assign asleep           = sleep_dly_r[SLEEP_CYCLES-1];
   assign SLEEP_ACTIVE_OUT = asleep;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic             advance;
   logic             flow;
   logic             selected;
   logic             step;
   logic [LANES-1:0] strobes;
   op_t              last_op_r;
   op_t              cmd_op;
   logic [LANES-1:0] cmd_lanes;

   // Sleep also freezes the pipeline so contents survive intact
   assign advance  = CLK_EN_IN && !ctl_s2_r[CTL_GATE] && !asleep;
   assign flow     = !ctl_s2_r[CTL_LAT];
   assign selected = !ctl_s2_r[CTL_SEL1] && ctl_s2_r[CTL_SEL2]
                     && !ctl_s2_r[CTL_SEL3];
   assign step     = ctl_s2_r[CTL_STEP];
   assign strobes  = ~ctl_s2_r[CTL_LANE0 +: LANES];

   always_comb begin
      cmd_op    = OP_DESEL;
      cmd_lanes = LANES_NONE;
      if (step) begin
         cmd_op = last_op_r;
      end else if (!selected) begin
         cmd_op = OP_DESEL;
      end else if (ctl_s2_r[CTL_STORE]) begin
         cmd_op = OP_READ;
      end else begin
         cmd_op = OP_WRITE;
      end
      // No strobe on a write leaves the lanes empty: a write abort
      if (cmd_op == OP_WRITE) begin
         cmd_lanes = strobes;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         last_op_r <= OP_DESEL;
      end else if (advance) begin
         last_op_r <= cmd_op;
      end
   end

   // ---------------------------------------------------------------
   // Burst address counter
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0]  base_r;
   logic [BURST_W-1:0] cnt_r;
   logic [BURST_W-1:0] cnt_next;
   logic [BURST_W-1:0] low_bits;
   logic [ADDR_W-1:0]  cmd_addr;

   assign cnt_next = cnt_r + CNT_ONE;

   always_comb begin
      if (ctl_s2_r[CTL_ORDER]) begin
         low_bits = base_r[BURST_W-1:0] ^ cnt_next;
      end else begin
         low_bits = base_r[BURST_W-1:0] + cnt_next;
      end
   end

   // The upper address bits never change inside a burst
   assign cmd_addr = step ? {base_r[ADDR_W-1:BURST_W], low_bits}
                          : addr_s2_r;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         base_r <= '0;
         cnt_r  <= CNT_RST;
      end else if (advance) begin
         if (step) begin
            cnt_r <= cnt_next;
         end else begin
            base_r <= addr_s2_r;
            cnt_r  <= CNT_RST;
         end
      end
   end

   // ---------------------------------------------------------------
   // Access pipeline
   // ---------------------------------------------------------------
   op_t               s1_op_r;
   logic [ADDR_W-1:0] s1_addr_r;
   logic [LANES-1:0]  s1_lanes_r;
   op_t               s2_op_r;
   logic [ADDR_W-1:0] s2_addr_r;
   logic [LANES-1:0]  s2_lanes_r;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         s1_op_r    <= OP_DESEL;
         s1_addr_r  <= '0;
         s1_lanes_r <= LANES_NONE;
         s2_op_r    <= OP_DESEL;
         s2_addr_r  <= '0;
         s2_lanes_r <= LANES_NONE;
      end else if (advance) begin
         s1_op_r    <= cmd_op;
         s1_addr_r  <= cmd_addr;
         s1_lanes_r <= cmd_lanes;
         s2_op_r    <= s1_op_r;
         s2_addr_r  <= s1_addr_r;
         s2_lanes_r <= s1_lanes_r;
      end
   end

   // ---------------------------------------------------------------
   // Memory lanes
   // ---------------------------------------------------------------
   // Single late write commits from stage one, double late from stage two
   logic [ADDR_W-1:0] wr_addr;
   logic [LANES-1:0]  wr_lanes;
   logic              wr_go;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_word;

   assign wr_go    = flow ? (s1_op_r == OP_WRITE) : (s2_op_r == OP_WRITE);
   assign wr_addr  = flow ? s1_addr_r : s2_addr_r;
   assign wr_lanes = flow ? s1_lanes_r : s2_lanes_r;
   assign rd_addr  = flow ? cmd_addr : s1_addr_r;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         logic [LANE_W-1:0] lane_mem [DEPTH];

         always_ff @(posedge SYS_CLK_IN) begin
            if (advance && wr_go && wr_lanes[g]) begin
               lane_mem[wr_addr] <= dq_s2_r[g*LANE_W +: LANE_W];
            end
         end

         assign rd_word[g*LANE_W +: LANE_W] = lane_mem[rd_addr];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Output register and drivers
   // ---------------------------------------------------------------
   // No forwarding: a read of a location whose late write is still
   // in flight returns the old contents.
   logic              rd_valid_r;
   logic [DATA_W-1:0] dq_out_r;
   logic              rd_now;

   assign rd_now = flow ? (cmd_op == OP_READ) : (s1_op_r == OP_READ);

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         rd_valid_r <= 1'b0;
      end else if (advance) begin
         rd_valid_r <= rd_now;
      end
   end

   // Frozen on a stall, so the bus keeps its value or stays floating
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         dq_out_r <= DQ_RST;
      end else if (advance && rd_now) begin
         dq_out_r <= rd_word;
      end
   end

   assign DQ_OUT    = dq_out_r;
   assign DQ_OE_OUT = rd_valid_r && !ctl_s2_r[CTL_DRIVE] && !asleep;

endmodule : sync_sram_core

`default_nettype wire
